// ### sdctm_regs.svh
// timing, field and pin-code constants for the sdram command-timing pair
`ifndef SDCTM_REGS_SVH
`define SDCTM_REGS_SVH
`define SDCTM_CLK_NS 40
`define SDCTM_CEIL(ns) (((ns) + `SDCTM_CLK_NS - 1) / `SDCTM_CLK_NS)
`define SDCTM_INIT_US 200
`define SDCTM_INIT_CYC ((`SDCTM_INIT_US * 1000 + `SDCTM_CLK_NS - 1) / `SDCTM_CLK_NS)
`define SDCTM_INIT_REFS 8
`define SDCTM_TREF_MS 64
`define SDCTM_REF_ROWS 4096
`define SDCTM_REF_CYC ((`SDCTM_TREF_MS * 1000000) / (`SDCTM_REF_ROWS * `SDCTM_CLK_NS))
`define SDCTM_TRCD_NS 30
`define SDCTM_TRP_NS 30
`define SDCTM_TRAS_NS 45
`define SDCTM_TRC_NS 75
`define SDCTM_TRRD_NS 20
`define SDCTM_TMRD_CLK 2
`define SDCTM_SREX_CLK 2
`define SDCTM_CAS_LAT 3
`define SDCTM_TDPL_CL3 2
`define SDCTM_TDPL_CL12 1
`define SDCTM_TDPL_ACT_CL3 5
`define SDCTM_TDPL_ACT_CL2 3
`define SDCTM_A10_BIT 10
`define SDCTM_MRS_CL_LSB 4
`define SDCTM_PIN_NOP 4'h7
`define SDCTM_PIN_ACT 4'h3
`define SDCTM_PIN_RD 4'h5
`define SDCTM_PIN_WR 4'h4
`define SDCTM_PIN_PRE 4'h2
`define SDCTM_PIN_REF 4'h1
`define SDCTM_PIN_MRS 4'h0
`endif

// ### sdctm_pkg.sv
// command type and pin encode/decode shared by both ends
`include "sdctm_regs.svh"
package sdctm_pkg;
   typedef enum {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS} sdctm_cmd_t;

   // pins are {cs_n, ras_n, cas_n, we_n}
   function automatic sdctm_cmd_t sdctm_decode(input logic [3:0] pins);
      sdctm_cmd_t c;
      c = CMD_NOP;
      if (pins == `SDCTM_PIN_ACT) c = CMD_ACT;
      else if (pins == `SDCTM_PIN_RD) c = CMD_RD;
      else if (pins == `SDCTM_PIN_WR) c = CMD_WR;
      else if (pins == `SDCTM_PIN_PRE) c = CMD_PRE;
      else if (pins == `SDCTM_PIN_REF) c = CMD_REF;
      else if (pins == `SDCTM_PIN_MRS) c = CMD_MRS;
      return c;
   endfunction : sdctm_decode

   function automatic logic [3:0] sdctm_encode(input sdctm_cmd_t c);
      logic [3:0] p;
      p = `SDCTM_PIN_NOP;
      case (c)
         CMD_ACT: p = `SDCTM_PIN_ACT;
         CMD_RD:  p = `SDCTM_PIN_RD;
         CMD_WR:  p = `SDCTM_PIN_WR;
         CMD_PRE: p = `SDCTM_PIN_PRE;
         CMD_REF: p = `SDCTM_PIN_REF;
         CMD_MRS: p = `SDCTM_PIN_MRS;
         default: p = `SDCTM_PIN_NOP;
      endcase
      return p;
   endfunction : sdctm_encode
endpackage : sdctm_pkg

// ### sdctm_if.sv
// memory pins between controller end and device end
`timescale 1ns/1ps
interface sdctm_if #(parameter int DW = 8);
   logic          cke;
   logic          cs_n;
   logic          ras_n;
   logic          cas_n;
   logic          we_n;
   logic          ba;
   logic [11:0]   addr;
   logic          dqm;
   logic [DW-1:0] dq_ctl;
   logic          dq_ctl_oe;
   logic [DW-1:0] dq_dev;
   logic          dq_dev_oe;
   logic [DW-1:0] dq;

   // shared data wire: device drive wins; an undriven wire reads as the inverse of
   // the last controller value, so a missing read burst cannot pass as the data last written
   assign dq = dq_dev_oe ? dq_dev : (dq_ctl_oe ? dq_ctl : ~dq_ctl);

   modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl, dq_ctl_oe,
                input dq);
   modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
                output dq_dev, dq_dev_oe);
endinterface : sdctm_if

// ### sdctm_dev.sv
// memory device end: command decode, clock suspend, self refresh, data masks
`timescale 1ns/1ps
`include "sdctm_regs.svh"
module sdctm_dev
   import sdctm_pkg::*;
#(
   parameter int DW    = 8,
   parameter int ROW_W = 4,
   parameter int COL_W = 4
) (
   input  wire logic       core_clk_i,
   input  wire logic       nrst_i,
   sdctm_if.dev            mem,
   output logic            self_refresh_o,
   output logic            suspended_o,
   output logic [2:0]      cas_lat_o,
   output logic [1:0]      bank_open_o,
   output logic [7:0]      refresh_cnt_o
);
   localparam int AW = 1 + ROW_W + COL_W;

   logic [DW-1:0]    mem_arr [2**AW];
   logic             susp_reg, susp_next;
   logic             sr_reg, sr_next;
   logic             arm_reg, arm_next;
   logic [1:0]       open_reg, open_next;
   logic [ROW_W-1:0] row_reg [2];
   logic [ROW_W-1:0] row_next [2];
   logic [2:0]       cl_reg, cl_next;
   logic [7:0]       ref_reg, ref_next;
   logic             dqm_reg;
   logic [2:0]       pv_reg, pv_next;
   logic [DW-1:0]    pd_reg [3];
   logic [DW-1:0]    pd_next [3];
   logic             run;
   logic             wr_en;
   logic             rd_ins;
   logic [AW-1:0]    idx;
   sdctm_cmd_t       cmd;

   // operations freeze one clock after a low clock enable is sampled
   assign run = !susp_reg && !sr_reg;
   assign cmd = run ? sdctm_decode({mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n}) : CMD_NOP;
   assign idx = {mem.ba, row_reg[mem.ba], mem.addr[COL_W-1:0]};

   // state, bank and mode tracking
   always_comb begin
      susp_next   = !mem.cke;
      sr_next     = sr_reg;
      arm_next    = arm_reg;
      open_next   = open_reg;
      row_next[0] = row_reg[0];
      row_next[1] = row_reg[1];
      cl_next     = cl_reg;
      ref_next    = ref_reg;
      wr_en       = 1'b0;
      rd_ins      = 1'b0;
      if (sr_reg) begin
         // exit begins on the second rising edge that sees the enable high
         if (!mem.cke) begin
            arm_next = 1'b0;
         end else if (arm_reg) begin
            sr_next  = 1'b0;
            arm_next = 1'b0;
         end else begin
            arm_next = 1'b1;
         end
      end
      case (cmd)
         CMD_ACT: begin
            open_next[mem.ba] = 1'b1;
            row_next[mem.ba]  = mem.addr[ROW_W-1:0];
         end
         CMD_PRE: begin
            if (mem.addr[`SDCTM_A10_BIT]) open_next = 2'h0;
            else open_next[mem.ba] = 1'b0;
         end
         CMD_REF: begin
            if (!mem.cke) sr_next = 1'b1;
            else ref_next = ref_reg + 8'h01;
         end
         CMD_MRS: cl_next = mem.addr[`SDCTM_MRS_CL_LSB +: 3];
         // write data sampled with the command, mask applies on the same edge
         CMD_WR:  wr_en = !mem.dqm;
         CMD_RD:  rd_ins = 1'b1;
         default: ;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         susp_reg  <= 1'b0;
         sr_reg    <= 1'b0;
         arm_reg   <= 1'b0;
         open_reg  <= 2'h0;
         row_reg[0] <= '0;
         row_reg[1] <= '0;
         cl_reg    <= 3'(`SDCTM_CAS_LAT);
         ref_reg   <= 8'h00;
         dqm_reg   <= 1'b0;
         pv_reg    <= 3'h0;
      end else begin
         susp_reg  <= susp_next;
         sr_reg    <= sr_next;
         arm_reg   <= arm_next;
         open_reg  <= open_next;
         row_reg[0] <= row_next[0];
         row_reg[1] <= row_next[1];
         cl_reg    <= cl_next;
         ref_reg   <= ref_next;
         dqm_reg   <= run ? mem.dqm : dqm_reg;
         pv_reg    <= pv_next;
      end
   end

   // storage has no reset, contents are undefined after power-up
   always_ff @(posedge core_clk_i) begin
      if (wr_en) mem_arr[idx] <= mem.dq;
      for (int k = 0; k < 3; k++) pd_reg[k] <= pd_next[k];
   end

   // read pipe: entry goes in at stage cl-1 and walks down to the drivers
   for (genvar k = 0; k < 3; k++) begin : g_pipe
      logic ins;
      logic v_up;
      assign ins  = rd_ins && (32'(cl_reg) == k + 1);
      assign v_up = (k < 2) ? pv_reg[(k < 2) ? k + 1 : k] : 1'b0;
      // output stage is dropped when the mask was sampled two clocks earlier
      assign pv_next[k] = !run ? pv_reg[k] :
                          (k == 0) ? ((ins || v_up) && !dqm_reg) : (ins || v_up);
      assign pd_next[k] = !run ? pd_reg[k] :
                          ins ? mem_arr[idx] : pd_reg[(k < 2) ? k + 1 : k];
   end

   assign mem.dq_dev     = pd_reg[0];
   assign mem.dq_dev_oe  = pv_reg[0];
   assign self_refresh_o = sr_reg;
   assign suspended_o    = susp_reg;
   assign cas_lat_o      = cl_reg;
   assign bank_open_o    = open_reg;
   assign refresh_cnt_o  = ref_reg;
endmodule : sdctm_dev

// ### sdctm_ctl.sv
// memory controller end: init sequence, refresh, row/column timing, request buffer
// Summary of operation
// - wait 200us, precharge all, 8 refreshes, mode set
// - 4096 refreshes every 64 ms
// - overdue refresh: one refresh per missed interval, up to 7 owed, back to back
// - self refresh exits on second edge
// - wait row cycle after self refresh exit
// - activate to column command waits tRCD
// - activates to different banks spaced tRRD
// - column commands may be one clock apart
// - write recovery before precharge by latency
// - last write data to activate/refresh spacing
// - read mask kills data two clocks later
// - write mask acts on same edge
// - clock suspend freezes after one clock
`timescale 1ns/1ps
`include "sdctm_regs.svh"
module sdctm_ctl
   import sdctm_pkg::*;
#(
   parameter int DW       = 8,
   parameter int ROW_W    = 4,
   parameter int COL_W    = 4,
   parameter int DEPTH    = 2,
   parameter int CL       = `SDCTM_CAS_LAT,
   parameter int INIT_CYC = `SDCTM_INIT_CYC,
   parameter int REF_CYC  = `SDCTM_REF_CYC
) (
   input  wire logic             core_clk_i,
   input  wire logic             nrst_i,
   sdctm_if.ctl                  mem,
   input  wire logic             req_valid_i,
   input  wire logic             req_write_i,
   input  wire logic             req_bank_i,
   input  wire logic [ROW_W-1:0] req_row_i,
   input  wire logic [COL_W-1:0] req_col_i,
   input  wire logic [DW-1:0]    req_wdata_i,
   input  wire logic             req_mask_i,
   input  wire logic             sr_req_i,
   output logic                  req_ready_o,
   output logic                  rd_valid_o,
   output logic [DW-1:0]         rd_data_o,
   output logic                  init_done_o,
   output logic                  sr_active_o
);
   typedef enum {ST_INIT, ST_IREF, ST_IDLE, ST_COL, ST_RDCAP, ST_PRE, ST_SR, ST_SRX} sdctm_st_t;

   localparam int EW   = 3 + ROW_W + COL_W + DW;
   localparam int PW   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW   = $clog2(DEPTH + 1);
   localparam int TDPL = (CL == 3) ? `SDCTM_TDPL_CL3 : `SDCTM_TDPL_CL12;
   localparam int TACT = (CL == 3) ? `SDCTM_TDPL_ACT_CL3 : `SDCTM_TDPL_ACT_CL2;
   localparam int TRP  = `SDCTM_CEIL(`SDCTM_TRP_NS);
   localparam int TRRD = `SDCTM_CEIL(`SDCTM_TRRD_NS);
   localparam int TPRE = (TRP > TRRD) ? TRP : TRRD;
   localparam int TWP  = (TACT - TDPL > TPRE) ? TACT - TDPL : TPRE;
   localparam logic [15:0] W_INIT = 16'(INIT_CYC - 1);
   localparam logic [15:0] W_TRCD = 16'(`SDCTM_CEIL(`SDCTM_TRCD_NS) - 1);
   localparam logic [15:0] W_TRAS = 16'(`SDCTM_CEIL(`SDCTM_TRAS_NS) - 1);
   localparam logic [15:0] W_TRC  = 16'(`SDCTM_CEIL(`SDCTM_TRC_NS) - 1);
   localparam logic [15:0] W_TPRE = 16'(TPRE - 1);
   localparam logic [15:0] W_TWP  = 16'(TWP - 1);
   localparam logic [15:0] W_TDPL = 16'(TDPL - 1);
   localparam logic [15:0] W_TMRD = 16'(`SDCTM_TMRD_CLK - 1);
   localparam logic [15:0] W_SREX = 16'(`SDCTM_SREX_CLK + `SDCTM_CEIL(`SDCTM_TRC_NS) - 1);
   localparam logic [15:0] W_CL   = 16'(CL);

   // request buffer
   logic [EW-1:0] fifo_mem [DEPTH];
   logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic          rdy_reg, rdy_next;
   logic          push, pop;
   logic [EW-1:0] head;

   assign push = req_valid_i && rdy_reg;
   assign head = fifo_mem[rp_reg];

   // ready is registered from the next fill level, so a full buffer stalls the source
   always_comb begin
      wp_next  = wp_reg;
      rp_next  = rp_reg;
      if (push) wp_next = (32'(wp_reg) == DEPTH - 1) ? '0 : PW'(wp_reg + 1'b1);
      if (pop) rp_next = (32'(rp_reg) == DEPTH - 1) ? '0 : PW'(rp_reg + 1'b1);
      cnt_next = CW'(cnt_reg + CW'(push) - CW'(pop));
      rdy_next = 32'(cnt_next) < DEPTH;
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
         rdy_reg <= 1'b0;
      end else begin
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
         rdy_reg <= rdy_next;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (push) fifo_mem[wp_reg] <= {req_write_i, req_bank_i, req_mask_i,
                                     req_row_i, req_col_i, req_wdata_i};
   end

   // refresh interval timer and refresh debt
   logic [15:0] tmr_reg, tmr_next;
   logic [2:0]  debt_reg, debt_next;
   logic        ref_issue;

   always_comb begin
      tmr_next  = tmr_reg + 16'h0001;
      debt_next = debt_reg - 3'(ref_issue);
      if (!init_done_o || sr_active_o) begin
         // the device keeps itself refreshed in self refresh
         tmr_next  = 16'h0000;
         debt_next = 3'h0;
      end else if (32'(tmr_reg) >= REF_CYC - 1) begin
         tmr_next = 16'h0000;
         if (debt_reg != 3'h7) debt_next = debt_reg - 3'(ref_issue) + 3'h1;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tmr_reg  <= 16'h0000;
         debt_reg <= 3'h0;
      end else begin
         tmr_reg  <= tmr_next;
         debt_reg <= debt_next;
      end
   end

   // command sequencer
   sdctm_st_t     st_reg, st_next;
   logic [15:0]   wait_reg, wait_next, ras_reg, ras_next;
   logic [3:0]    icnt_reg, icnt_next;
   logic [EW-1:0] cur_reg, cur_next;
   logic          cke_reg, cke_next, ba_reg, ba_next, dqm_reg, dqm_next, oe_reg, oe_next;
   logic [3:0]    pin_reg, pin_next;
   logic [11:0]   addr_reg, addr_next;
   logic [DW-1:0] dq_reg, dq_next, rdd_reg, rdd_next;
   logic          rdv_reg, rdv_next, done_reg, done_next, sra_reg, sra_next;
   logic          go;

   assign go = (wait_reg == 16'h0000);

   always_comb begin
      st_next   = st_reg;
      wait_next = go ? wait_reg : wait_reg - 16'h0001;
      ras_next  = (ras_reg == 16'h0000) ? ras_reg : ras_reg - 16'h0001;
      icnt_next = icnt_reg;
      cur_next  = cur_reg;
      cke_next  = cke_reg;
      pin_next  = sdctm_encode(CMD_NOP);
      ba_next   = ba_reg;
      addr_next = addr_reg;
      dqm_next  = 1'b0;
      oe_next   = 1'b0;
      dq_next   = dq_reg;
      rdv_next  = 1'b0;
      rdd_next  = rdd_reg;
      done_next = done_reg;
      sra_next  = sra_reg;
      pop       = 1'b0;
      ref_issue = 1'b0;
      case (st_reg)
         ST_INIT: if (go) begin
            pin_next  = sdctm_encode(CMD_PRE);
            addr_next = 12'h000;
            addr_next[`SDCTM_A10_BIT] = 1'b1;
            wait_next = W_TPRE;
            st_next   = ST_IREF;
         end
         ST_IREF: if (go) begin
            if (32'(icnt_reg) == `SDCTM_INIT_REFS) begin
               pin_next  = sdctm_encode(CMD_MRS);
               addr_next = 12'h000;
               addr_next[`SDCTM_MRS_CL_LSB +: 3] = 3'(CL);
               wait_next = W_TMRD;
               done_next = 1'b1;
               st_next   = ST_IDLE;
            end else begin
               pin_next  = sdctm_encode(CMD_REF);
               icnt_next = icnt_reg + 4'h1;
               wait_next = W_TRC;
            end
         end
         ST_IDLE: if (go) begin
            if (debt_reg != 3'h0) begin
               // an overdue debt of two or more drains back to back
               pin_next  = sdctm_encode(CMD_REF);
               ref_issue = 1'b1;
               wait_next = W_TRC;
            end else if (sr_req_i) begin
               pin_next = sdctm_encode(CMD_REF);
               cke_next = 1'b0;
               sra_next = 1'b1;
               st_next  = ST_SR;
            end else if (cnt_reg != '0) begin
               pop       = 1'b1;
               cur_next  = head;
               pin_next  = sdctm_encode(CMD_ACT);
               ba_next   = head[EW-2];
               addr_next = 12'(head[DW+COL_W +: ROW_W]);
               ras_next  = W_TRAS;
               wait_next = W_TRCD;
               st_next   = ST_COL;
            end
         end
         ST_COL: if (go) begin
            addr_next = 12'(cur_reg[DW +: COL_W]);
            if (cur_reg[EW-1]) begin
               pin_next  = sdctm_encode(CMD_WR);
               dq_next   = cur_reg[DW-1:0];
               oe_next   = 1'b1;
               dqm_next  = cur_reg[EW-3];
               wait_next = W_TDPL;
               st_next   = ST_PRE;
            end else begin
               pin_next  = sdctm_encode(CMD_RD);
               wait_next = W_CL;
               st_next   = ST_RDCAP;
            end
         end
         ST_RDCAP: if (go) begin
            rdv_next = 1'b1;
            rdd_next = mem.dq;
            st_next  = ST_PRE;
         end
         ST_PRE: if (go && ras_reg == 16'h0000) begin
            // rows close right after one access, far inside the maximum open time
            pin_next  = sdctm_encode(CMD_PRE);
            addr_next = 12'h000;
            wait_next = cur_reg[EW-1] ? W_TWP : W_TPRE;
            st_next   = ST_IDLE;
         end
         ST_SR: if (!sr_req_i) begin
            cke_next  = 1'b1;
            wait_next = W_SREX;
            st_next   = ST_SRX;
         end
         ST_SRX: if (go) begin
            sra_next = 1'b0;
            st_next  = ST_IDLE;
         end
         default: st_next = ST_INIT;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg   <= ST_INIT;
         wait_reg <= W_INIT;
         ras_reg  <= 16'h0000;
         icnt_reg <= 4'h0;
         cur_reg  <= '0;
         cke_reg  <= 1'b1;
         pin_reg  <= `SDCTM_PIN_NOP;
         ba_reg   <= 1'b0;
         addr_reg <= 12'h000;
         dqm_reg  <= 1'b0;
         oe_reg   <= 1'b0;
         dq_reg   <= '0;
         rdv_reg  <= 1'b0;
         rdd_reg  <= '0;
         done_reg <= 1'b0;
         sra_reg  <= 1'b0;
      end else begin
         st_reg   <= st_next;
         wait_reg <= wait_next;
         ras_reg  <= ras_next;
         icnt_reg <= icnt_next;
         cur_reg  <= cur_next;
         cke_reg  <= cke_next;
         pin_reg  <= pin_next;
         ba_reg   <= ba_next;
         addr_reg <= addr_next;
         dqm_reg  <= dqm_next;
         oe_reg   <= oe_next;
         dq_reg   <= dq_next;
         rdv_reg  <= rdv_next;
         rdd_reg  <= rdd_next;
         done_reg <= done_next;
         sra_reg  <= sra_next;
      end
   end

   assign {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} = pin_reg;
   assign mem.cke       = cke_reg;
   assign mem.ba        = ba_reg;
   assign mem.addr      = addr_reg;
   assign mem.dqm       = dqm_reg;
   assign mem.dq_ctl    = dq_reg;
   assign mem.dq_ctl_oe = oe_reg;
   assign req_ready_o   = rdy_reg;
   assign rd_valid_o    = rdv_reg;
   assign rd_data_o     = rdd_reg;
   assign init_done_o   = done_reg;
   assign sr_active_o   = sra_reg;
endmodule : sdctm_ctl

// ### sdctm_asserts.sv
// pin-level timing checks between the controller end and the device end
`timescale 1ns/1ps
`include "sdctm_regs.svh"
module sdctm_asserts #(
   parameter int INIT_CYC = 20,
   parameter int REF_CYC  = 40
) (
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   input  wire logic        cke,
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic [11:0] addr,
   input  wire logic        dqm,
   input  wire logic        dq_ctl_oe,
   input  wire logic        dq_dev_oe
);
   logic [3:0]  pins;
   logic [15:0] cyc_reg, cyc_next, gap_reg, gap_next;
   logic [3:0]  refs_reg, refs_next;
   logic        mrs_reg, mrs_next;

   assign pins = {cs_n, ras_n, cas_n, we_n};

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   // time since reset, refreshes seen, gap since the last refresh
   always_comb begin
      cyc_next  = (cyc_reg == 16'hffff) ? cyc_reg : cyc_reg + 16'h0001;
      refs_next = (pins == `SDCTM_PIN_REF && refs_reg != 4'hf) ? refs_reg + 4'h1 : refs_reg;
      mrs_next  = mrs_reg | (pins == `SDCTM_PIN_MRS);
      // cke low means self refresh: the device keeps its own rows then
      gap_next  = (pins == `SDCTM_PIN_REF || !cke) ? 16'h0000 : gap_reg + 16'h0001;
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cyc_reg  <= 16'h0000;
         gap_reg  <= 16'h0000;
         refs_reg <= 4'h0;
         mrs_reg  <= 1'b0;
      end else begin
         cyc_reg  <= cyc_next;
         gap_reg  <= gap_next;
         refs_reg <= refs_next;
         mrs_reg  <= mrs_next;
      end
   end

   sequence s_wr;
      pins == `SDCTM_PIN_WR;
   endsequence
   // one-cycle data burst, latency edges after the edge that sees the read
   sequence s_rd_data;
      !dq_dev_oe [*3] ##1 dq_dev_oe ##1 !dq_dev_oe;
   endsequence

   chk_init_quiet: assert property (cyc_reg < INIT_CYC |-> pins == `SDCTM_PIN_NOP)
      else $error("command before power-up wait ended");
   chk_mrs_after_refs: assert property (pins == `SDCTM_PIN_MRS |-> refs_reg >= 4'h8)
      else $error("mode set before eight refreshes");
   chk_init_pre_all: assert property (pins == `SDCTM_PIN_PRE && !mrs_reg |->
      addr[`SDCTM_A10_BIT])
      else $error("init precharge not for all banks");
   chk_refresh_gap: assert property (mrs_reg |-> gap_reg <= REF_CYC + 12)
      else $error("refresh interval overrun");
   chk_act_then_col: assert property (pins == `SDCTM_PIN_ACT |=>
      pins == `SDCTM_PIN_RD || pins == `SDCTM_PIN_WR)
      else $error("activate not followed by column command");
   chk_wr_data_cmd: assert property ((pins == `SDCTM_PIN_WR) == dq_ctl_oe)
      else $error("write data not driven with write command");
   chk_mask_on_write: assert property (dqm |-> pins == `SDCTM_PIN_WR)
      else $error("mask raised outside a write");
   chk_wr_no_pre: assert property (s_wr |=> pins != `SDCTM_PIN_PRE)
      else $error("precharge inside write recovery");
   chk_wr_to_act: assert property (s_wr |=>
      (pins != `SDCTM_PIN_ACT && pins != `SDCTM_PIN_REF) [*4])
      else $error("activate or refresh too soon after write");
   chk_rd_data_lat: assert property (pins == `SDCTM_PIN_RD && cke |-> s_rd_data)
      else $error("read data not driven at latency");
   chk_sr_exit_wait: assert property ($rose(cke) |-> (pins == `SDCTM_PIN_NOP) [*4])
      else $error("command inside self refresh exit time");
endmodule : sdctm_asserts

// ### sdram_command_timing_tb.sv
// self-checking bench: controller and device joined over the memory pins
`timescale 1ns/1ps
module sdram_command_timing_tb;
   logic       core_clk_i, nrst_i, req_valid_i, req_write_i, req_bank_i, req_mask_i;
   logic       sr_req_i, req_ready_o, rd_valid_o, init_done_o, sr_active_o;
   logic       self_refresh_o, suspended_o;
   logic [2:0] cas_lat_o;
   logic [1:0] bank_open_o;
   logic [3:0] req_row_i, req_col_i;
   logic [7:0] req_wdata_i, rd_data_o, refresh_cnt_o, ref_before;
   int         num_errors, tests_run, cycles;

   sdctm_if #(.DW(8)) i_sdctm_if ();
   // short init and refresh counts keep the run brief
   sdctm_ctl #(.INIT_CYC(20), .REF_CYC(40)) i_sdctm_ctl (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i), .mem(i_sdctm_if),
      .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_bank_i(req_bank_i),
      .req_row_i(req_row_i), .req_col_i(req_col_i), .req_wdata_i(req_wdata_i),
      .req_mask_i(req_mask_i), .sr_req_i(sr_req_i), .req_ready_o(req_ready_o),
      .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .init_done_o(init_done_o),
      .sr_active_o(sr_active_o));
   sdctm_dev i_sdctm_dev (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i), .mem(i_sdctm_if),
      .self_refresh_o(self_refresh_o), .suspended_o(suspended_o), .cas_lat_o(cas_lat_o),
      .bank_open_o(bank_open_o), .refresh_cnt_o(refresh_cnt_o));
   sdctm_asserts #(.INIT_CYC(20), .REF_CYC(40)) i_sdctm_asserts (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i), .cke(i_sdctm_if.cke),
      .cs_n(i_sdctm_if.cs_n), .ras_n(i_sdctm_if.ras_n), .cas_n(i_sdctm_if.cas_n),
      .we_n(i_sdctm_if.we_n), .addr(i_sdctm_if.addr), .dqm(i_sdctm_if.dqm),
      .dq_ctl_oe(i_sdctm_if.dq_ctl_oe), .dq_dev_oe(i_sdctm_if.dq_dev_oe));

   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   // hang guard: the tests need well under a thousand cycles
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         report_and_stop();
      end
   end

   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check_byte

   task automatic check_bit(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   // bounded wait for a level; entered and left just after a rising edge
   task automatic wait_for(ref logic sig, input logic lvl);
      int n;
      n = 0;
      while (sig !== lvl && n < 2000) begin
         @(posedge core_clk_i);
         n++;
      end
      check_bit("wait level", lvl, sig);
   endtask : wait_for

   // valid is left high so back-to-back pushes never write it twice in one step
   task automatic push(input logic w, b, input logic [3:0] row, col,
                       input logic [7:0] d, input logic m);
      int n;
      n = 0;
      req_valid_i <= 1'b1;
      req_write_i <= w;
      req_bank_i  <= b;
      req_row_i   <= row;
      req_col_i   <= col;
      req_wdata_i <= d;
      req_mask_i  <= m;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (req_ready_o !== 1'b1 && n < 2000);
      // a request never taken counts as a mismatch
      check_bit("request taken", 1'b1, req_ready_o);
   endtask : push

   task automatic idle();
      req_valid_i <= 1'b0;
      @(posedge core_clk_i);
   endtask : idle

   task automatic read_chk(input logic b, input logic [3:0] row, col, input logic [7:0] exp);
      push(1'b0, b, row, col, 8'h00, 1'b0);
      idle();
      wait_for(rd_valid_o, 1'b1);
      check_byte("read data", exp, rd_data_o);
   endtask : read_chk

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   initial begin
      {nrst_i, req_valid_i, req_write_i, req_bank_i, req_mask_i, sr_req_i} = 6'h00;
      {req_row_i, req_col_i, req_wdata_i} = 16'h0000;
      {num_errors, tests_run, cycles} = {32'h0, 32'h0, 32'h0};
      repeat (8) @(posedge core_clk_i);
      check_bit("ready in reset", 1'b0, req_ready_o);
      nrst_i <= 1'b1;
      @(posedge core_clk_i);
      // two writes wait in the buffer until init ends
      push(1'b1, 1'b0, 4'h3, 4'h5, 8'ha5, 1'b0);
      push(1'b1, 1'b1, 4'h3, 4'h5, 8'h5a, 1'b0);
      idle();
      check_bit("buffer full", 1'b0, req_ready_o);
      wait_for(init_done_o, 1'b1);
      check_byte("refreshes at init", 8'h08, refresh_cnt_o);
      check_byte("cas latency", 8'h03, {5'h00, cas_lat_o});
      $display("test init done");
      read_chk(1'b0, 4'h3, 4'h5, 8'ha5);
      read_chk(1'b1, 4'h3, 4'h5, 8'h5a);
      push(1'b1, 1'b0, 4'h3, 4'h5, 8'h11, 1'b1);
      idle();
      read_chk(1'b0, 4'h3, 4'h5, 8'ha5);
      push(1'b1, 1'b0, 4'h3, 4'h6, 8'h22, 1'b0);
      push(1'b1, 1'b0, 4'h3, 4'h6, 8'h33, 1'b0);
      idle();
      read_chk(1'b0, 4'h3, 4'h6, 8'h33);
      $display("test data done");
      ref_before = refresh_cnt_o;
      repeat (90) @(posedge core_clk_i);
      check_bit("periodic refresh", 1'b1, (refresh_cnt_o - ref_before) >= 8'h02);
      $display("test refresh done");
      check_byte("banks closed", 8'h00, {6'h00, bank_open_o});
      sr_req_i <= 1'b1;
      wait_for(self_refresh_o, 1'b1);
      @(posedge core_clk_i);
      check_bit("clock enable", 1'b0, i_sdctm_if.cke);
      check_bit("device suspended", 1'b1, suspended_o);
      sr_req_i <= 1'b0;
      wait_for(sr_active_o, 1'b0);
      check_bit("self refresh left", 1'b0, self_refresh_o);
      read_chk(1'b1, 4'h3, 4'h5, 8'h5a);
      $display("test self refresh done");
      report_and_stop();
   end
endmodule : sdram_command_timing_tb
